// file: icsc_pkg.sv
package icsc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ICSC_CH0_CONTROL_ADDR = 8'h00_C0;
    localparam logic [7:0] ICSC_CH1_CONTROL_ADDR = 8'h00_D0;
    localparam logic [7:0] ICSC_CH2_CONTROL_ADDR = 8'h00_E0;
    localparam int         ICSC_NUM_CH           = 3;
    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int ICSC_SEQ_STOP_BIT  = 7;
    localparam int ICSC_START_BIT     = 6;
    localparam int ICSC_BYTE_STOP_BIT = 5;
    localparam int ICSC_TRIG_POL_BIT  = 4;
    localparam int ICSC_TRIG_EN_BIT   = 3;
    localparam logic [7:0] ICSC_CONTROL_RESET = 8'h00_00;
    // Bits that store a value; pointer resets and bit 0 read back as zero
    localparam logic [7:0] ICSC_CONTROL_RW_MASK = 8'h00_18;
    // Frame repeat count values named in the clear conditions
    localparam logic [7:0] ICSC_FRAME_ZERO = 8'h00_00;
    localparam logic [7:0] ICSC_FRAME_ONE  = 8'h00_01;
    // ----------------------------------------------------------------
    // Channel states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ICSC_ST_IDLE   = 2'b00,
        ICSC_ST_CHECK  = 2'b01,
        ICSC_ST_ACTIVE = 2'b10,
        ICSC_ST_STOP   = 2'b11
    } icsc_state_e;
endpackage

// file: icsc_channel.sv
`timescale 1ns/100ps
module icsc_channel
    import icsc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    // Host write of this channel's control register
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    // Channel context
    input  wire logic       i_channel_enable_bit,
    input  wire logic [7:0] i_frame_repeat_count,
    // Serial engine status
    input  wire logic       i_bus_busy,
    input  wire logic       i_stop_seen,
    input  wire logic       i_byte_done,
    input  wire logic       i_seq_done,
    input  wire logic       i_loop_done,
    input  wire logic       i_reading,
    input  wire logic       i_err_event,
    // Register and engine controls
    output logic      [7:0] o_control,
    output logic            o_gen_start,
    output logic            o_gen_stop,
    output logic            o_gen_nack,
    output logic            o_bus_data_error_flag,
    output logic            o_err_report,
    output logic            o_active
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    icsc_state_e st_q, st_d;
    logic [7:0]  ctl_q, ctl_d;        // Stored control bits
    logic        start_q, start_d;    // Pulse outputs, registered
    logic        stop_q, stop_d;
    logic        nack_q, nack_d;
    logic        berr_q, berr_d;      // Bus error flag, sticky
    logic        erep_q, erep_d;
    logic        act_q, act_d;        // Not-idle flag, registered so the port has no decode
    logic        sseq, sbyte, sreq;
    logic        wr_start, wr_sseq, wr_sbyte;

    assign sseq  = ctl_q[ICSC_SEQ_STOP_BIT];
    assign sbyte = ctl_q[ICSC_BYTE_STOP_BIT];
    assign sreq  = ctl_q[ICSC_START_BIT];
    assign wr_start = i_wr && i_wdata[ICSC_START_BIT];
    assign wr_sseq  = i_wr && i_wdata[ICSC_SEQ_STOP_BIT];
    assign wr_sbyte = i_wr && i_wdata[ICSC_BYTE_STOP_BIT];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        ctl_d   = ctl_q;
        start_d = 1'b0;
        stop_d  = 1'b0;
        nack_d  = 1'b0;
        berr_d  = berr_q;
        erep_d  = 1'b0;
        // Trigger bits only change while the channel is idle
        if (i_wr && st_q == ICSC_ST_IDLE) begin
            ctl_d = (ctl_q & ~ICSC_CONTROL_RW_MASK) | (i_wdata & ICSC_CONTROL_RW_MASK);
        end
        // Writing zeros never aborts anything, so only ones are acted on
        if (wr_start && i_channel_enable_bit && st_q == ICSC_ST_IDLE) begin // RULE11 RULE17 RULE7
            ctl_d[ICSC_START_BIT] = 1'b1;
        end
        // Stop requests are dropped while no start is pending
        if (wr_sseq && sreq) begin // RULE15
            ctl_d[ICSC_SEQ_STOP_BIT] = 1'b1;
        end
        if (wr_sbyte && sreq) begin // RULE15
            ctl_d[ICSC_BYTE_STOP_BIT] = 1'b1;
        end
        // Errors keep being reported up to the last bit, even when stopping
        // Any non-idle state counts, so the check cycle is covered as well
        if (i_err_event && st_q != ICSC_ST_IDLE) begin
            erep_d = 1'b1; // RULE4
        end
        case (st_q)
            ICSC_ST_IDLE: begin
                if (sreq) begin
                    st_d = ICSC_ST_CHECK;
                end
            end
            ICSC_ST_CHECK: begin
                // Check the bus before driving a START
                if (i_bus_busy) begin // RULE5 RULE6
                    berr_d = 1'b1;
                    ctl_d[ICSC_START_BIT] = 1'b0;
                    st_d = ICSC_ST_IDLE;
                end else begin
                    start_d = 1'b1; // RULE5
                    st_d    = ICSC_ST_ACTIVE;
                end
            end
            ICSC_ST_ACTIVE: begin
                // Byte stop wins over sequence stop when both are pending
                if (sbyte && i_byte_done) begin // RULE12 RULE16
                    nack_d = i_reading; // RULE13
                    stop_d = 1'b1;
                    ctl_d[ICSC_START_BIT] = 1'b0; // RULE10
                    st_d = ICSC_ST_STOP;
                end else if (sseq && i_seq_done) begin // RULE2
                    stop_d = 1'b1;
                    if (i_frame_repeat_count == ICSC_FRAME_ZERO
                        || i_frame_repeat_count > ICSC_FRAME_ONE) begin
                        ctl_d[ICSC_START_BIT] = 1'b0; // RULE9
                    end
                    st_d = ICSC_ST_STOP;
                end else if ((i_seq_done && i_frame_repeat_count == ICSC_FRAME_ONE)
                             || (i_loop_done && i_frame_repeat_count > ICSC_FRAME_ONE)) begin
                    ctl_d[ICSC_START_BIT] = 1'b0; // RULE8
                    stop_d = 1'b1;
                    st_d = ICSC_ST_STOP;
                end
            end
            ICSC_ST_STOP: begin
                // Stop flags clear once the STOP shows on the bus
                if (i_stop_seen) begin
                    ctl_d[ICSC_SEQ_STOP_BIT]  = 1'b0; // RULE3
                    ctl_d[ICSC_BYTE_STOP_BIT] = 1'b0; // RULE14
                    ctl_d[ICSC_START_BIT]     = 1'b0;
                    st_d = ICSC_ST_IDLE;
                end
            end
            default: begin
                st_d = ICSC_ST_IDLE;
            end
        endcase
        // Follows the next state, so the flag matches the state register exactly
        act_d = (st_d != ICSC_ST_IDLE);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q    <= ICSC_ST_IDLE;
            ctl_q   <= ICSC_CONTROL_RESET;
            start_q <= 1'b0;
            stop_q  <= 1'b0;
            nack_q  <= 1'b0;
            berr_q  <= 1'b0;
            erep_q  <= 1'b0;
            act_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            ctl_q   <= ctl_d;
            start_q <= start_d;
            stop_q  <= stop_d;
            nack_q  <= nack_d;
            berr_q  <= berr_d;
            erep_q  <= erep_d;
            act_q   <= act_d;
        end
    end

    assign o_control             = ctl_q;
    assign o_gen_start           = start_q;
    assign o_gen_stop            = stop_q;
    assign o_gen_nack            = nack_q;
    assign o_bus_data_error_flag = berr_q;
    assign o_err_report          = erep_q;
    assign o_active              = act_q;
endmodule

// file: icsc_top.sv
`timescale 1ns/100ps
// Function
// RULE1: Three 8-bit control registers at C0h, D0h, E0h
// RULE2: Sequence stop ends after sequence with STOP
// RULE3: Sequence stop bit clears on bus STOP
// RULE4: Errors still reported until last bit
// RULE5: Start request checks bus free, then START
// RULE6: Busy bus sets error flag, interrupt low
// RULE7: Host sets start only when idle
// RULE8: Start clears at sequence or loop completion
// RULE9: Start clears on sequence stop, count 0/>1
// RULE10: Start clears when byte stop byte done
// RULE11: Start cannot set while channel disabled
// RULE12: Byte stop ends after current byte
// RULE13: Read in progress gets NACK before STOP
// RULE14: Byte stop bit clears on bus STOP
// RULE15: Stop writes ignored while start is zero
// RULE16: Byte stop beats sequence stop
// RULE17: Writing zeros causes no action
module icsc_top
    import icsc_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_resetn,
    // Parallel host port
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire logic [7:0]             i_addr,
    input  wire logic [7:0]             i_wdata,
    // Channel context from the wider controller
    input  wire logic [ICSC_NUM_CH-1:0] i_channel_enable_bit,
    input  wire logic [7:0]             i_frame_repeat_count [ICSC_NUM_CH],
    // Serial engine status, one bit per channel
    input  wire logic [ICSC_NUM_CH-1:0] i_bus_busy,
    input  wire logic [ICSC_NUM_CH-1:0] i_stop_seen,
    input  wire logic [ICSC_NUM_CH-1:0] i_byte_done,
    input  wire logic [ICSC_NUM_CH-1:0] i_seq_done,
    input  wire logic [ICSC_NUM_CH-1:0] i_loop_done,
    input  wire logic [ICSC_NUM_CH-1:0] i_reading,
    input  wire logic [ICSC_NUM_CH-1:0] i_err_event,
    // Read data
    output logic      [7:0]             o_rdata,
    // Engine controls
    output logic      [ICSC_NUM_CH-1:0] o_gen_start,
    output logic      [ICSC_NUM_CH-1:0] o_gen_stop,
    output logic      [ICSC_NUM_CH-1:0] o_gen_nack,
    output logic      [ICSC_NUM_CH-1:0] o_err_report,
    output logic      [ICSC_NUM_CH-1:0] o_bus_data_error_flag,
    output logic      [ICSC_NUM_CH-1:0] o_active,
    // Interrupt, active low
    output logic                        o_int_n
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_ADDR [ICSC_NUM_CH] =
        '{ICSC_CH0_CONTROL_ADDR, ICSC_CH1_CONTROL_ADDR, ICSC_CH2_CONTROL_ADDR};
    logic [7:0]             ctl [ICSC_NUM_CH];
    logic [ICSC_NUM_CH-1:0] berr;
    logic [7:0]             rdata_d, rdata_q;
    logic                   int_n_q;

    // One channel per control register
    for (genvar c = 0; c < ICSC_NUM_CH; c++) begin : g_ch
        icsc_channel u_ch (
            .i_clk_sys            (i_clk_sys),
            .i_resetn             (i_resetn),
            .i_wr                 (i_wr && i_addr == CH_ADDR[c]), // RULE1
            .i_wdata              (i_wdata),
            .i_channel_enable_bit (i_channel_enable_bit[c]),
            .i_frame_repeat_count (i_frame_repeat_count[c]),
            .i_bus_busy           (i_bus_busy[c]),
            .i_stop_seen          (i_stop_seen[c]),
            .i_byte_done          (i_byte_done[c]),
            .i_seq_done           (i_seq_done[c]),
            .i_loop_done          (i_loop_done[c]),
            .i_reading            (i_reading[c]),
            .i_err_event          (i_err_event[c]),
            .o_control            (ctl[c]),
            .o_gen_start          (o_gen_start[c]),
            .o_gen_stop           (o_gen_stop[c]),
            .o_gen_nack           (o_gen_nack[c]),
            .o_bus_data_error_flag(berr[c]),
            .o_err_report         (o_err_report[c]),
            .o_active             (o_active[c])
        );
    end

    // ----------------------------------------------------------------
    // Read mux; unmapped addresses read zero
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00_00;
        for (int c = 0; c < ICSC_NUM_CH; c++) begin
            if (i_rd && i_addr == CH_ADDR[c]) begin // RULE1
                rdata_d = ctl[c];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= 8'h00_00;
            int_n_q <= 1'b1;
        end else begin
            rdata_q <= rdata_d;
            int_n_q <= ~(|berr); // RULE6
        end
    end

    assign o_rdata               = rdata_q;
    assign o_bus_data_error_flag = berr;
    assign o_int_n               = int_n_q;
endmodule

// file: icsc_properties.sv
`timescale 1ns/100ps
module icsc_checker
    import icsc_pkg::*;
(
    // Clock, reset and host port
    input wire logic                   i_clk_sys,
    input wire logic                   i_resetn,
    input wire logic                   i_wr,
    input wire logic [7:0]             i_addr,
    input wire logic [ICSC_NUM_CH-1:0] i_channel_enable_bit,
    // Engine side
    input wire logic [ICSC_NUM_CH-1:0] i_bus_busy,
    input wire logic [ICSC_NUM_CH-1:0] i_stop_seen,
    input wire logic [ICSC_NUM_CH-1:0] i_err_event,
    input wire logic [ICSC_NUM_CH-1:0] o_gen_start,
    input wire logic [ICSC_NUM_CH-1:0] o_gen_stop,
    input wire logic [ICSC_NUM_CH-1:0] o_gen_nack,
    input wire logic [ICSC_NUM_CH-1:0] o_err_report,
    input wire logic [ICSC_NUM_CH-1:0] o_bus_data_error_flag,
    input wire logic [ICSC_NUM_CH-1:0] o_active,
    input wire logic                   o_int_n
);
    // One clock domain, so a shared clock and reset
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    property p_start_free;
        o_gen_start[0] |-> !$past(i_bus_busy[0]);
    endproperty
    a_start_free: assert property (p_start_free) else $error("start on a busy bus");
    property p_start_act;
        o_gen_start[0] |-> o_active[0];
    endproperty
    a_start_act: assert property (p_start_act) else $error("start while idle");
    property p_err_nostart;
        $rose(o_bus_data_error_flag[0]) |-> !o_gen_start[0] && $past(i_bus_busy[0]);
    endproperty
    a_err_nostart: assert property (p_err_nostart) else $error("bad bus error");
    property p_flag_hold;
        o_bus_data_error_flag[0] |=> o_bus_data_error_flag[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("error flag lost");
    property p_int_low;
        (|o_bus_data_error_flag) |=> !o_int_n;
    endproperty
    a_int_low: assert property (p_int_low) else $error("interrupt not low");
    property p_nack_stop;
        o_gen_nack[0] |-> o_gen_stop[0];
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("nack without stop");
    property p_err_fwd;
        i_err_event[0] && o_active[0] |=> o_err_report[0];
    endproperty
    a_err_fwd: assert property (p_err_fwd) else $error("error not reported");
    property p_no_start_dis;
        i_wr && i_addr == ICSC_CH0_CONTROL_ADDR && !i_channel_enable_bit[0] && !o_active[0]
            |=> !o_gen_start[0] [*2];
    endproperty
    a_no_start_dis: assert property (p_no_start_dis) else $error("start when off");
    property p_idle_stop;
        o_gen_stop[0] ##[1:20] i_stop_seen[0] |=> !o_active[0];
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("not idle after stop");
endmodule
bind icsc_top icsc_checker u_icsc_checker (
    .i_clk_sys, .i_resetn, .i_wr, .i_addr, .i_channel_enable_bit, .i_bus_busy,
    .i_stop_seen, .i_err_event, .o_gen_start, .o_gen_stop, .o_gen_nack,
    .o_err_report, .o_bus_data_error_flag, .o_active, .o_int_n
);

// file: icsc_engine_model.sv
`timescale 1ns/100ps
module icsc_engine_model #(
    parameter int BYTE_CYC  = 4,  // Cycles per serial byte
    parameter int SEQ_BYTES = 3   // Bytes in one stored sequence
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_resetn,
    // Requests from the channel, and a foreign master holding the bus
    input  wire logic i_gen_start,
    input  wire logic i_gen_stop,
    input  wire logic i_other_master,
    // Bus status back
    output logic      o_bus_busy,
    output logic      o_byte_done,
    output logic      o_seq_done,
    output logic      o_stop_seen
);
    int   cyc_q;   // Cycle within the byte
    int   byte_q;  // Byte within the sequence
    int   stop_q;  // Countdown until our STOP is on the wires
    logic run_q;   // Bytes moving
    // Bus owned from START until our STOP; a foreign master also holds it
    assign o_bus_busy = run_q || stop_q != 0 || i_other_master;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            {run_q, o_byte_done, o_seq_done, o_stop_seen} <= '0;
            {cyc_q, byte_q, stop_q} <= '0;
        end else begin
            o_byte_done <= run_q && cyc_q == BYTE_CYC - 1;
            o_seq_done  <= run_q && cyc_q == BYTE_CYC - 1 && byte_q == SEQ_BYTES - 1;
            o_stop_seen <= stop_q == 1;
            cyc_q       <= (run_q && cyc_q < BYTE_CYC - 1) ? cyc_q + 1 : 0;
            if (run_q && cyc_q == BYTE_CYC - 1)
                byte_q <= (byte_q == SEQ_BYTES - 1) ? 0 : byte_q + 1;
            if (stop_q != 0)
                stop_q <= stop_q - 1;
            if (i_gen_start) begin
                run_q  <= 1'b1;
                byte_q <= 0;
            end
            // Bytes stop at once; the STOP shows a few cycles later
            if (i_gen_stop) begin
                run_q  <= 1'b0;
                stop_q <= 3;
            end
        end
    end
endmodule

// file: icsc_top_tb.sv
`timescale 1ns/100ps
module icsc_top_tb;
    import icsc_pkg::*;
    logic i_clk_sys = 0, i_resetn = 0, i_wr = 0, i_rd = 0, other_q = 0;
    logic [7:0] i_addr = '0, i_wdata = '0, o_rdata, i_frame_repeat_count [ICSC_NUM_CH];
    logic [2:0] i_channel_enable_bit = '1, i_loop_done = '0, i_reading = '0, i_err_event = '0;
    logic [2:0] o_gen_start, o_gen_stop, o_gen_nack, o_err_report, o_bus_data_error_flag, o_active;
    logic       o_int_n, m_busy, m_byte, m_seq, m_stop;
    wire logic [2:0] i_bus_busy = {other_q, other_q, m_busy};
    wire logic [2:0] i_byte_done = {2'b00, m_byte};
    wire logic [2:0] i_seq_done = {2'b00, m_seq};
    wire logic [2:0] i_stop_seen = {2'b00, m_stop};
    int err_count = 0, check_count = 0, n_st = 0, n_sp = 0, n_nk = 0, n_rp = 0, n_sq = 0, n_s1 = 0;
    int cyc = 0;
    icsc_top DUT (.i_clk_sys, .i_resetn, .i_wr, .i_rd, .i_addr, .i_wdata, .i_channel_enable_bit,
        .i_frame_repeat_count, .i_bus_busy, .i_stop_seen, .i_byte_done, .i_seq_done,
        .i_loop_done, .i_reading, .i_err_event, .o_rdata, .o_gen_start, .o_gen_stop,
        .o_gen_nack, .o_err_report, .o_bus_data_error_flag, .o_active, .o_int_n);
    icsc_engine_model u_eng (.i_clk_sys, .i_resetn, .i_gen_start(o_gen_start[0]),
        .i_gen_stop(o_gen_stop[0]), .i_other_master(other_q), .o_bus_busy(m_busy),
        .o_byte_done(m_byte), .o_seq_done(m_seq), .o_stop_seen(m_stop));
    always #12.5 i_clk_sys = ~i_clk_sys;
    // Pulses tallied mid-cycle; a hang ends the run after the limit
    always @(negedge i_clk_sys) begin
        n_st += int'(o_gen_start[0]);
        n_sp += int'(o_gen_stop[0]);
        n_nk += int'(o_gen_nack[0]);
        n_rp += int'(o_err_report[0]);
        n_sq += int'(m_seq);
        n_s1 += int'(o_gen_start[1]);
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
        @(negedge i_clk_sys);
        i_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk_sys);
        {i_addr, i_rd} = {a, 1'b1};
        @(negedge i_clk_sys);
        i_rd = 0;
        check("read data", o_rdata, exp);
    endtask
    task automatic wait_idle;
        repeat (200) if (o_active[0] !== 1'b0) @(negedge i_clk_sys);
        check("active", 8'(o_active[0]), 8'h00_00);
    endtask
    task automatic stop_test;
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_refused;
        i_channel_enable_bit[0] = 0;
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
        i_channel_enable_bit[0] = 1;
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_A0);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
        check("starts", 8'(n_st), 8'h00_00);
    endtask
    task automatic t_frame_one;
        i_frame_repeat_count[0] = 8'h00_01;
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        wait_idle();
        check("starts", 8'(n_st), 8'h00_01);
        check("stops", 8'(n_sp), 8'h00_01);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
    endtask
    task automatic t_byte_stop;
        int q;
        {i_frame_repeat_count[0], i_reading[0], q} = {8'h00_00, 1'b1, n_sq};
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_E0);
        i_err_event[0] = 1;
        @(negedge i_clk_sys);
        i_err_event[0] = 0;
        wait_idle();
        i_reading[0] = 0;
        check("nacks", 8'(n_nk), 8'h00_01);
        check("reports", 8'(n_rp), 8'h00_01);
        check("sequences", 8'(n_sq - q), 8'h00_00);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
    endtask
    task automatic t_seq_stop;
        int q;
        q = n_sq;
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_C0);
        wait_idle();
        check("sequences", 8'(n_sq - q), 8'h00_01);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
        // Repeat count above one: the stop still ends after one sequence
        i_frame_repeat_count[0] = 8'h00_02;
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_C0);
        wait_idle();
        check("sequences", 8'(n_sq - q), 8'h00_02);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
    endtask
    task automatic t_loop;
        i_frame_repeat_count[0] = 8'h00_02;
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        repeat (20) @(negedge i_clk_sys);
        i_loop_done[0] = 1;
        @(negedge i_clk_sys);
        i_loop_done[0] = 0;
        wait_idle();
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
    endtask
    task automatic t_busy;
        wr(ICSC_CH1_CONTROL_ADDR, 8'h00_40);
        repeat (4) @(negedge i_clk_sys);
        check("channel 1 start", 8'(n_s1), 8'h00_01);
        other_q = 1;
        wr(ICSC_CH0_CONTROL_ADDR, 8'h00_40);
        repeat (3) @(negedge i_clk_sys);
        check("error flag", 8'(o_bus_data_error_flag[0]), 8'h00_01);
        check("interrupt", 8'(o_int_n), 8'h00_00);
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
    endtask
    initial begin
        i_frame_repeat_count = '{default: 8'h00_00};
        repeat (3) @(negedge i_clk_sys);
        i_resetn = 1;
        rd(ICSC_CH0_CONTROL_ADDR, 8'h00_00);
        rd(ICSC_CH1_CONTROL_ADDR, 8'h00_00);
        rd(ICSC_CH2_CONTROL_ADDR, 8'h00_00);
        rd(8'h00_C1, 8'h00_00);
        t_refused();
        t_frame_one();
        t_byte_stop();
        t_seq_stop();
        t_loop();
        t_busy();
        stop_test();
    end
endmodule
